// [ittd_pkg.sv]
// Purpose: shared constants for the infrared capture / transmit timer pair
// Assumes: 8-bit register port into the timer register bank, one clock
// Notes: offsets are register indexes within the bank
package ittd_pkg;

   // register offsets within the timer bank
   localparam logic [3:0] ADDR_NARROW_CTRL = 4'h0; // narrow_timer_control
   localparam logic [3:0] ADDR_COMMON_CTRL = 4'h1; // common_timer_control
   localparam logic [3:0] ADDR_WIDE_CTRL = 4'h2; // wide_timer_control
   localparam logic [3:0] ADDR_RELOAD_LO = 4'h6; // wide_reload_low_byte
   localparam logic [3:0] ADDR_RELOAD_HI = 4'h7; // wide_reload_high_byte
   localparam logic [3:0] ADDR_WCAP_LO = 4'h8; // wide_capture_low_byte
   localparam logic [3:0] ADDR_WCAP_HI = 4'h9; // wide_capture_high_byte
   localparam logic [3:0] ADDR_NCAP_LO = 4'ha; // narrow_capture_low
   localparam logic [3:0] ADDR_NCAP_HI = 4'hb; // narrow_capture_high

   // narrow and wide control field positions
   localparam int CTL_ENABLE = 0; // timer enable
   localparam int CTL_TOUT_IE = 1; // timeout interrupt enable
   localparam int CTL_CAP_IE = 2; // capture interrupt enable
   localparam int CTL_MODULO = 3; // wide: 1 modulo-n, 0 single-pass
   localparam int CTL_DEMOD = 4; // wide: demodulation mode
   localparam int CTL_TOUT_ST = 5; // timeout status, write one to clear

   // common control field positions
   localparam int COM_INIT = 0; // initial output level on write
   localparam int COM_FALL_ST = 0; // falling edge status on read
   localparam int COM_RISE_ST = 1; // rising edge status on read
   localparam int COM_FORCE_LO = 2; // force field low bit
   localparam int COM_FORCE_HI = 3; // force field high bit
   localparam int COM_EDGE_LO = 4; // edge select low bit
   localparam int COM_EDGE_HI = 5; // edge select high bit

   // field encodings
   localparam logic [1:0] FORCE_ZERO = 2'h2; // output held at 0
   localparam logic [1:0] FORCE_ONE = 2'h3; // output held at 1
   localparam logic [1:0] EDGE_RISE = 2'h1; // rising edges only
   localparam logic [1:0] EDGE_FALL = 2'h2; // falling edges only
   localparam logic [1:0] EDGE_BOTH = 2'h3; // both edges

   // reset and reload values
   localparam logic [7:0] CTRL_RESET = 8'h00; // all control registers
   localparam logic [7:0] NARROW_TOP = 8'hff; // narrow reload value
   localparam logic [15:0] WIDE_TOP = 16'hffff; // wide demod reload value

   // wide timer sequencer, one-hot
   typedef enum logic [4:0] {
      WS_IDLE = 5'h01, // disabled
      WS_TX_RUN = 5'h02, // transmit counting
      WS_TX_DONE = 5'h04, // single-pass finished
      WS_DM_ARM = 5'h08, // demod, waiting first edge
      WS_DM_RUN = 5'h10 // demod, measuring
   } ittd_wide_state_t;

endpackage

// [ittd_edge_sync.sv]
// Purpose: bring the modulated input into the clock domain and find edges
// Assumes: input is asynchronous to clk
// Notes: a change counts once the second and third stages agree
module ittd_edge_sync (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // raw pin
   input wire logic pin_in,
   // synchronised level and edge pulses
   output logic level,
   output logic rise,
   output logic fall
);

   logic s1_r; // first stage, read only by s2
   logic s2_r; // second stage
   logic s3_r; // third stage

   // three-stage synchroniser
   always_ff @(posedge clk) begin
      if (reset) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // accepted level and its edges
   always_ff @(posedge clk) begin
      if (reset) begin
         level <= 1'b0;
         rise <= 1'b0;
         fall <= 1'b0;
      end else begin
         rise <= 1'b0;
         fall <= 1'b0;
         // take the new value only when stages two and three agree
         if (s2_r == s3_r && s3_r != level) begin
            level <= s3_r;
            rise <= s3_r;
            fall <= ~s3_r;
         end
      end
   end

endmodule

// [ittd_timer_pair.sv]
// Purpose: narrow demodulation timer and wide transmit/demodulation timer
// Assumes: register port in the timer bank, counters step every clock
// Notes: read data appears one clock after the read strobe
module ittd_timer_pair (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // link pins
   input wire logic ir_in,
   output logic wide_timer_output,
   // interrupt requests
   output logic narrow_irq,
   output logic wide_irq
);

   // registers written by software
   logic [7:0] narrow_ctrl_r; // enable and interrupt enables
   logic [7:0] common_ctrl_r; // force, edge select; bits 1:0 unused
   logic [7:0] wide_ctrl_r; // enable, enables, mode bits
   logic init_level_r; // initial output level
   logic [7:0] reload_lo_r; // wide_reload_low_byte
   logic [7:0] reload_hi_r; // wide_reload_high_byte
   // status flags
   logic narrow_tout_r; // narrow timeout
   logic wide_tout_r; // wide timeout
   logic edge_rise_r; // edge status, rising
   logic edge_fall_r; // edge status, falling
   // counters and captures
   logic [7:0] narrow_count_r; // narrow down-counter
   logic [15:0] wide_count_r; // wide down-counter
   logic [7:0] ncap_lo_r; // narrow_capture_low
   logic [7:0] ncap_hi_r; // narrow_capture_high
   logic [15:0] wcap_r; // wide capture pair
   ittd_pkg::ittd_wide_state_t wstate_r; // wide sequencer
   logic wide_en_r; // enable seen last cycle
   // synchronised input
   logic in_level; // accepted input level
   logic in_rise; // rising edge pulse
   logic in_fall; // falling edge pulse
   // decoded strobes
   logic wr_narrow; // write to narrow control
   logic wr_common; // write to common control
   logic wr_wide; // write to wide control
   logic narrow_cap; // narrow capture event
   logic narrow_zero; // narrow timeout event
   logic wide_sel_edge; // selected edge for wide demod
   logic wide_cap; // wide capture event
   logic wide_zero; // wide reaches zero
   logic wide_start; // rising enable
   logic [15:0] reload_val; // reload pair as one count

   // edge finder on the modulated input
   ittd_edge_sync u_sync (
      .clk(clk),
      .reset(reset),
      .pin_in(ir_in),
      .level(in_level),
      .rise(in_rise),
      .fall(in_fall)
   );

   // true when an edge matches the select field
   function automatic logic edge_match(input logic [1:0] sel, input logic r, input logic f);
      case (sel)
         ittd_pkg::EDGE_RISE: edge_match = r;
         ittd_pkg::EDGE_FALL: edge_match = f;
         ittd_pkg::EDGE_BOTH: edge_match = r | f;
         default: edge_match = 1'b0;
      endcase
   endfunction

   // write-one-to-clear flag with set winning over clear
   function automatic logic sticky(input logic cur, input logic set, input logic clr);
      sticky = set | (cur & ~clr);
   endfunction

   // write decodes
   assign wr_narrow = reg_wr && reg_addr == ittd_pkg::ADDR_NARROW_CTRL;
   assign wr_common = reg_wr && reg_addr == ittd_pkg::ADDR_COMMON_CTRL;
   assign wr_wide = reg_wr && reg_addr == ittd_pkg::ADDR_WIDE_CTRL;
   assign reload_val = {reload_hi_r, reload_lo_r}; // high byte times 256 plus low byte

   // narrow timer events
   assign narrow_cap = narrow_ctrl_r[ittd_pkg::CTL_ENABLE] & (in_rise | in_fall);
   assign narrow_zero = narrow_ctrl_r[ittd_pkg::CTL_ENABLE] & ~narrow_cap & narrow_count_r == 8'h00;

   // wide timer events
   assign wide_start = wide_ctrl_r[ittd_pkg::CTL_ENABLE] & ~wide_en_r;
   assign wide_sel_edge = edge_match(common_ctrl_r[ittd_pkg::COM_EDGE_HI:ittd_pkg::COM_EDGE_LO], in_rise, in_fall);
   assign wide_cap = wstate_r == ittd_pkg::WS_DM_RUN && wide_sel_edge;
   // reaching zero is a step from one; zero itself wraps quietly
   assign wide_zero = (wstate_r == ittd_pkg::WS_TX_RUN || wstate_r == ittd_pkg::WS_DM_RUN) && !wide_cap
      && wide_count_r == 16'h0001;

   // software control registers
   always_ff @(posedge clk) begin
      if (reset) begin
         narrow_ctrl_r <= ittd_pkg::CTRL_RESET;
         common_ctrl_r <= ittd_pkg::CTRL_RESET;
         wide_ctrl_r <= ittd_pkg::CTRL_RESET;
         init_level_r <= 1'b0;
      end else begin
         // status bit positions are held elsewhere, kept zero here
         if (wr_narrow) begin
            narrow_ctrl_r <= reg_wdata & ~(8'h01 << ittd_pkg::CTL_TOUT_ST);
         end
         if (wr_common) begin
            common_ctrl_r <= reg_wdata & 8'hfc;
            init_level_r <= reg_wdata[ittd_pkg::COM_INIT];
         end
         if (wr_wide) begin
            wide_ctrl_r <= reg_wdata & ~(8'h01 << ittd_pkg::CTL_TOUT_ST);
         end
      end
   end

   // reload bytes, free to write at any time
   always_ff @(posedge clk) begin
      if (reset) begin
         reload_lo_r <= 8'h00;
         reload_hi_r <= 8'h00;
      end else if (reg_wr) begin
         // only copied into the counter at a load
         if (reg_addr == ittd_pkg::ADDR_RELOAD_LO) begin
            reload_lo_r <= reg_wdata;
         end
         if (reg_addr == ittd_pkg::ADDR_RELOAD_HI) begin
            reload_hi_r <= reg_wdata;
         end
      end
   end

   // sticky status flags
   always_ff @(posedge clk) begin
      if (reset) begin
         narrow_tout_r <= 1'b0;
         wide_tout_r <= 1'b0;
         edge_rise_r <= 1'b0;
         edge_fall_r <= 1'b0;
      end else begin
         narrow_tout_r <= sticky(narrow_tout_r, narrow_zero, wr_narrow & reg_wdata[ittd_pkg::CTL_TOUT_ST]);
         wide_tout_r <= sticky(wide_tout_r, wide_zero, wr_wide & reg_wdata[ittd_pkg::CTL_TOUT_ST]);
         // either timer's capture marks the edge that caused it
         edge_rise_r <= sticky(edge_rise_r, (narrow_cap | wide_cap) & in_rise,
            wr_common & reg_wdata[ittd_pkg::COM_RISE_ST]);
         edge_fall_r <= sticky(edge_fall_r, (narrow_cap | wide_cap) & in_fall,
            wr_common & reg_wdata[ittd_pkg::COM_FALL_ST]);
      end
   end

   // narrow timer: count down, capture on edges
   always_ff @(posedge clk) begin
      if (reset) begin
         narrow_count_r <= ittd_pkg::NARROW_TOP;
         ncap_lo_r <= 8'h00;
         ncap_hi_r <= 8'h00;
      end else if (!narrow_ctrl_r[ittd_pkg::CTL_ENABLE]) begin
         narrow_count_r <= ittd_pkg::NARROW_TOP;
      end else if (narrow_cap) begin
         // elapsed counts since last reload
         if (in_rise) begin
            ncap_lo_r <= ~narrow_count_r; // low phase just ended
         end else begin
            ncap_hi_r <= ~narrow_count_r; // high phase just ended
         end
         narrow_count_r <= ittd_pkg::NARROW_TOP;
      end else if (narrow_zero) begin
         narrow_count_r <= ittd_pkg::NARROW_TOP;
      end else begin
         narrow_count_r <= narrow_count_r - 8'h01;
      end
   end

   // wide timer sequencer and counter
   always_ff @(posedge clk) begin
      if (reset) begin
         wstate_r <= ittd_pkg::WS_IDLE;
         wide_count_r <= 16'h0000;
         wcap_r <= 16'h0000;
         wide_en_r <= 1'b0;
      end else begin
         wide_en_r <= wide_ctrl_r[ittd_pkg::CTL_ENABLE];
         if (!wide_ctrl_r[ittd_pkg::CTL_ENABLE]) begin
            wstate_r <= ittd_pkg::WS_IDLE;
         end else if (wide_start) begin
            // enable edge picks the mode
            if (wide_ctrl_r[ittd_pkg::CTL_DEMOD]) begin
               wstate_r <= ittd_pkg::WS_DM_ARM;
            end else begin
               wstate_r <= ittd_pkg::WS_TX_RUN;
               wide_count_r <= reload_val;
            end
         end else begin
            case (wstate_r)
               ittd_pkg::WS_TX_RUN: begin
                  if (wide_zero) begin
                     if (wide_ctrl_r[ittd_pkg::CTL_MODULO]) begin
                        wide_count_r <= reload_val;
                     end else begin
                        wide_count_r <= 16'h0000;
                        wstate_r <= ittd_pkg::WS_TX_DONE;
                     end
                  end else begin
                     wide_count_r <= wide_count_r - 16'h0001;
                  end
               end
               ittd_pkg::WS_DM_ARM: begin
                  if (wide_sel_edge) begin
                     wcap_r <= ~wide_count_r;
                     wide_count_r <= reload_val;
                     wstate_r <= ittd_pkg::WS_DM_RUN;
                  end
               end
               ittd_pkg::WS_DM_RUN: begin
                  if (wide_cap) begin
                     wcap_r <= ~wide_count_r;
                     wide_count_r <= ittd_pkg::WIDE_TOP;
                  end else if (wide_zero) begin
                     wide_count_r <= ittd_pkg::WIDE_TOP;
                  end else begin
                     wide_count_r <= wide_count_r - 16'h0001;
                  end
               end
               ittd_pkg::WS_TX_DONE: begin
                  wstate_r <= ittd_pkg::WS_TX_DONE;
               end
               default: begin
                  wstate_r <= ittd_pkg::WS_IDLE;
               end
            endcase
         end
      end
   end

   // transmit output pin
   always_ff @(posedge clk) begin
      if (reset) begin
         wide_timer_output <= 1'b1;
      end else if (common_ctrl_r[ittd_pkg::COM_FORCE_HI:ittd_pkg::COM_FORCE_LO] == ittd_pkg::FORCE_ZERO) begin
         wide_timer_output <= 1'b0;
      end else if (common_ctrl_r[ittd_pkg::COM_FORCE_HI:ittd_pkg::COM_FORCE_LO] == ittd_pkg::FORCE_ONE) begin
         wide_timer_output <= 1'b1;
      end else if (!wide_ctrl_r[ittd_pkg::CTL_ENABLE]) begin
         wide_timer_output <= ~init_level_r;
      end else if (wide_start && !wide_ctrl_r[ittd_pkg::CTL_DEMOD]) begin
         wide_timer_output <= init_level_r;
      end else if (wide_zero && wstate_r == ittd_pkg::WS_TX_RUN) begin
         wide_timer_output <= ~wide_timer_output;
      end
   end

   // interrupt requests follow status and enables
   always_ff @(posedge clk) begin
      if (reset) begin
         narrow_irq <= 1'b0;
         wide_irq <= 1'b0;
      end else begin
         narrow_irq <= (narrow_tout_r & narrow_ctrl_r[ittd_pkg::CTL_TOUT_IE])
            | ((edge_rise_r | edge_fall_r) & narrow_ctrl_r[ittd_pkg::CTL_CAP_IE]);
         wide_irq <= (wide_tout_r & wide_ctrl_r[ittd_pkg::CTL_TOUT_IE])
            | ((edge_rise_r | edge_fall_r) & wide_ctrl_r[ittd_pkg::CTL_CAP_IE]);
      end
   end

   // read port, data one clock after the strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ittd_pkg::ADDR_NARROW_CTRL: reg_rdata <= narrow_ctrl_r | ({7'h00, narrow_tout_r} << ittd_pkg::CTL_TOUT_ST);
            ittd_pkg::ADDR_COMMON_CTRL: reg_rdata <= {common_ctrl_r[7:2], edge_rise_r, edge_fall_r};
            ittd_pkg::ADDR_WIDE_CTRL: reg_rdata <= wide_ctrl_r | ({7'h00, wide_tout_r} << ittd_pkg::CTL_TOUT_ST);
            ittd_pkg::ADDR_RELOAD_LO: reg_rdata <= reload_lo_r;
            ittd_pkg::ADDR_RELOAD_HI: reg_rdata <= reload_hi_r;
            ittd_pkg::ADDR_WCAP_LO: reg_rdata <= wcap_r[7:0];
            ittd_pkg::ADDR_WCAP_HI: reg_rdata <= wcap_r[15:8];
            ittd_pkg::ADDR_NCAP_LO: reg_rdata <= ncap_lo_r;
            ittd_pkg::ADDR_NCAP_HI: reg_rdata <= ncap_hi_r;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // checks on the timer behaviour
   sequence s_wide_hit_zero;
      wide_zero && wstate_r == ittd_pkg::WS_TX_RUN;
   endsequence

   sequence s_single_pass;
      s_wide_hit_zero ##0 !wide_ctrl_r[ittd_pkg::CTL_MODULO] && !wr_wide;
   endsequence

   a_narrow_rise_cap: assert property (@(posedge clk) disable iff (reset)
      narrow_cap && in_rise |=> ncap_lo_r == ~$past(narrow_count_r))
      else $error("narrow rising capture not in low register");

   a_narrow_reload: assert property (@(posedge clk) disable iff (reset)
      narrow_cap && !wr_narrow |=> narrow_count_r == 8'hff)
      else $error("narrow timer not reloaded after capture");

   a_narrow_timeout: assert property (@(posedge clk) disable iff (reset)
      narrow_zero |=> narrow_tout_r && narrow_count_r == 8'hff)
      else $error("narrow timeout not flagged or not reloaded");

   a_force_output: assert property (@(posedge clk) disable iff (reset)
      common_ctrl_r[3:2] == 2'h2 ##1 common_ctrl_r[3:2] == 2'h2 |-> !wide_timer_output)
      else $error("forced low output not low");

   a_disabled_level: assert property (@(posedge clk) disable iff (reset)
      !wide_ctrl_r[0] && !common_ctrl_r[3] |=> wide_timer_output == ~$past(init_level_r))
      else $error("disabled output not inverse of initial level");

   a_wide_load: assert property (@(posedge clk) disable iff (reset)
      wide_start && !wide_ctrl_r[4] && !wr_wide |=> wide_count_r == $past(reload_val) ##1 wide_en_r)
      else $error("wide timer not loaded from reload pair");

   a_single_stop: assert property (@(posedge clk) disable iff (reset)
      s_single_pass |=> wstate_r == ittd_pkg::WS_TX_DONE ##1 wide_count_r == 16'h0000)
      else $error("single-pass timer did not stop");

   a_wide_toggle: assert property (@(posedge clk) disable iff (reset)
      s_wide_hit_zero ##0 !common_ctrl_r[3] && !wr_common && !wr_wide |=> wide_timer_output != $past(wide_timer_output)
      && wide_tout_r)
      else $error("wide zero did not toggle output or set status");

   a_zero_wrap: assert property (@(posedge clk) disable iff (reset)
      wstate_r == ittd_pkg::WS_TX_RUN && wide_count_r == 16'h0000 && !wr_wide && !wide_tout_r
      |=> wide_count_r == 16'hffff && !wide_tout_r)
      else $error("zero count did not wrap quietly");

   a_wide_capture: assert property (@(posedge clk) disable iff (reset)
      wide_cap && !wr_wide |=> wcap_r == ~$past(wide_count_r) && wide_count_r == 16'hffff)
      else $error("wide capture not complemented or not reloaded");

   a_status_irq: assert property (@(posedge clk) disable iff (reset)
      wide_tout_r && wide_ctrl_r[1] |=> wide_irq)
      else $error("enabled wide status did not raise interrupt");

endmodule

// [ittd_ir_source.sv]
// Purpose: model of the modulated infrared source on ir_in
// Assumes: the bench calls hold at a falling clock edge
// Notes: the level only moves when the bench asks for it
module ittd_ir_source (
   // clock
   input wire logic clk,
   // pin toward the block
   output logic ir_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle level before any burst
   initial ir_out = 1'b0;
   // hold one level for n clock cycles, edges spaced well over 2 clocks
   task automatic hold(input logic lvl, input int n);
      ir_out = lvl;
      repeat (n) @(negedge clk);
   endtask
endmodule

// [tb_ir_timer_transmit_demod.sv]
// Purpose: self-checking bench for the infrared timer pair
// Assumes: register strobes pulse one cycle, inputs move at falling edges
// Notes: capture counts are allowed one clock of slack for pipeline phase
module tb_ir_timer_transmit_demod;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, reset = 1'b1; // clock and reset
   logic [3:0] reg_addr = 4'h0; // register port
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic ir_in, wide_timer_output, narrow_irq, wide_irq; // pins
   int fail_count = 0, samples_checked = 0, cyc = 0;
   ittd_timer_pair dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ir_in(ir_in),
      .wide_timer_output(wide_timer_output), .narrow_irq(narrow_irq), .wide_irq(wide_irq));
   ittd_ir_source src_u (.clk(clk), .ir_out(ir_in));
   // free running clock
   initial forever #4 clk = ~clk;
   // cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   // compare one value
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one register write, held across one rising edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   // one register read, data taken once settled
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask
   // single pass, modulo-n, force and idle level of the transmit output
   task automatic t_tx();
      logic [7:0] v;
      logic p;
      int n;
      wr(ittd_pkg::ADDR_RELOAD_LO, 8'h05);
      wr(ittd_pkg::ADDR_RELOAD_HI, 8'h00);
      wr(ittd_pkg::ADDR_COMMON_CTRL, 8'h00);
      wr(ittd_pkg::ADDR_WIDE_CTRL, 8'h01);
      repeat (3) @(negedge clk);
      check(wide_timer_output, 1'b0);
      repeat (6) @(negedge clk);
      check(wide_timer_output, 1'b1);
      check(wide_irq, 1'b0);
      repeat (20) @(negedge clk);
      check(wide_timer_output, 1'b1);
      rd(ittd_pkg::ADDR_WIDE_CTRL, v);
      check(v[5], 1'b1);
      wr(ittd_pkg::ADDR_WIDE_CTRL, 8'h03);
      @(negedge clk);
      check(wide_irq, 1'b1);
      wr(ittd_pkg::ADDR_WIDE_CTRL, 8'h23);
      @(negedge clk);
      check(wide_irq, 1'b0);
      wr(ittd_pkg::ADDR_WIDE_CTRL, 8'h00);
      wr(ittd_pkg::ADDR_WIDE_CTRL, 8'h09);
      @(negedge clk);
      p = wide_timer_output;
      n = 0;
      repeat (48) begin
         @(negedge clk);
         if (wide_timer_output !== p) n++;
         p = wide_timer_output;
      end
      check(16'(n), 16'h0009);
      wr(ittd_pkg::ADDR_COMMON_CTRL, 8'h08);
      @(negedge clk);
      check(wide_timer_output, 1'b0);
      wr(ittd_pkg::ADDR_COMMON_CTRL, 8'h0c);
      @(negedge clk);
      check(wide_timer_output, 1'b1);
      wr(ittd_pkg::ADDR_COMMON_CTRL, 8'h01);
      wr(ittd_pkg::ADDR_WIDE_CTRL, 8'h00);
      repeat (2) @(negedge clk);
      check(wide_timer_output, 1'b0);
      // a zero initial count wraps to all ones without a timeout
      wr(ittd_pkg::ADDR_RELOAD_LO, 8'h00);
      wr(ittd_pkg::ADDR_WIDE_CTRL, 8'h21);
      repeat (10) @(negedge clk);
      check(wide_timer_output, 1'b1);
      rd(ittd_pkg::ADDR_WIDE_CTRL, v);
      check(v[5], 1'b0);
      wr(ittd_pkg::ADDR_WIDE_CTRL, 8'h00);
      $display("test tx done");
   endtask
   // narrow capture of a high pulse, status, write guard and timeout
   task automatic t_narrow();
      logic [7:0] v;
      wr(ittd_pkg::ADDR_COMMON_CTRL, 8'h03);
      wr(ittd_pkg::ADDR_NARROW_CTRL, 8'h05);
      src_u.hold(1'b0, 10);
      src_u.hold(1'b1, 20);
      src_u.hold(1'b0, 10);
      rd(ittd_pkg::ADDR_NCAP_HI, v);
      check(16'(v == 8'h13 || v == 8'h14), 16'h0001);
      rd(ittd_pkg::ADDR_COMMON_CTRL, v);
      check(v[1:0], 2'b11);
      check(narrow_irq, 1'b1);
      wr(ittd_pkg::ADDR_NCAP_HI, 8'h55);
      rd(ittd_pkg::ADDR_NCAP_HI, v);
      check(16'(v == 8'h13 || v == 8'h14), 16'h0001);
      src_u.hold(1'b0, 300);
      rd(ittd_pkg::ADDR_NARROW_CTRL, v);
      check(v[5], 1'b1);
      wr(ittd_pkg::ADDR_NARROW_CTRL, 8'h20);
      $display("test narrow done");
   endtask
   // wide demodulation between two rising edges
   task automatic t_demod();
      logic [7:0] v;
      wr(ittd_pkg::ADDR_COMMON_CTRL, 8'h13);
      wr(ittd_pkg::ADDR_RELOAD_LO, 8'hff);
      wr(ittd_pkg::ADDR_RELOAD_HI, 8'hff);
      wr(ittd_pkg::ADDR_WIDE_CTRL, 8'h15);
      src_u.hold(1'b1, 10);
      src_u.hold(1'b0, 10);
      src_u.hold(1'b1, 10);
      rd(ittd_pkg::ADDR_WCAP_HI, v);
      check(v, 8'h00);
      rd(ittd_pkg::ADDR_WCAP_LO, v);
      check(16'(v == 8'h13 || v == 8'h14), 16'h0001);
      check(wide_irq, 1'b1);
      $display("test demod done");
   endtask
   // verdict and end of run
   task automatic wrap_up();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (16) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      check(wide_timer_output, 1'b1);
      check({narrow_irq, wide_irq}, 2'b00);
      t_tx();
      t_narrow();
      t_demod();
      wrap_up();
   end
endmodule
